/* File: verilog/fldm_pkg.sv */
// Purpose: shared constants and types for the fast link-drop monitor
// Assumes: 100 MHz core clock, 16-bit register port with 8-bit addresses
// Notes:   every offset, field position, reset value and time lives here
package fldm_pkg;

   // register port
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;

   localparam logic [ADDR_W-1:0] ADDR_WIN_CNT   = 8'h2C;
   localparam logic [ADDR_W-1:0] ADDR_CFG       = 8'h2D;
   localparam logic [ADDR_W-1:0] ADDR_THR       = 8'h2E;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 8'h40;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 8'h41;

   // config/status register fields
   localparam int unsigned CFG_SILENCE_BIT = 15;
   localparam int unsigned CFG_SKIP_BIT    = 14;
   localparam int unsigned CFG_CAUSE_LSB   = 8;
   localparam int unsigned CFG_MODES_LSB   = 0;
   localparam int unsigned N_CRIT          = 5;

   // criterion positions, shared by enables and cause flags
   localparam int unsigned CRIT_ENERGY = 0;
   localparam int unsigned CRIT_MSE    = 1;
   localparam int unsigned CRIT_MLT3   = 2;
   localparam int unsigned CRIT_RXERR  = 3;
   localparam int unsigned CRIT_DESCR  = 4;

   // threshold register fields
   localparam int unsigned THR_W       = 3;
   localparam int unsigned THR_WIN_LSB = 8;
   localparam int unsigned THR_ON_LSB  = 4;
   localparam int unsigned THR_OFF_LSB = 0;
   localparam logic [DATA_W-1:0] THR_RST = 16'h0221;

   // criteria window field
   localparam int unsigned WIN_CNT_W   = 5;
   localparam int unsigned WIN_CNT_LSB = 9;
   localparam logic [WIN_CNT_W-1:0] WIN_CNT_RST = 5'h0A;

   // interrupt status bits
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_DROP_BIT  = 0;
   localparam int unsigned IRQ_SILENT_BIT = 1;
   localparam int unsigned IRQ_ELOST_BIT = 2;

   // timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_NS       = 1000;
   localparam int unsigned TICK_W        = 7;
   localparam logic [TICK_W-1:0] TICK_CYCLES =
      TICK_W'(TICK_NS / CLK_PERIOD_NS);
   localparam int unsigned WAIT_W          = 8;
   localparam int unsigned MAX_WAIT_US_DEF = 8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } fldm_bus_req_t;

   typedef struct packed {
      logic signal_present;
      logic energy_sample;
      logic mse_bad;
      logic mlt3_err;
      logic rx_err;
      logic descr_sync_lost;
   } fldm_rx_ind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DOWN = 2'b10
   } fldm_state_t;

endpackage

/* File: verilog/fldm_pulse_div.sv */
// Purpose: programmable divider giving one-cycle pulses every period enables
// Assumes: period_i is static between pulses; zero behaves as one
// Notes:   pulse is registered
`timescale 1ns/1ns
`default_nettype none
module fldm_pulse_div #(
   parameter int unsigned W = 5
) (
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         resetn_i,
   // control
   input  wire logic         en_i,
   input  wire logic [W-1:0] period_i,
   // result
   output logic              pulse_o
);
   logic [W-1:0] cnt_reg;
   logic         last;

   assign last = (W'(cnt_reg + 1'b1) >= period_i) || (&cnt_reg);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= '0;
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= en_i && last;
         if (en_i) begin
            cnt_reg <= last ? '0 : W'(cnt_reg + 1'b1);
         end
      end
   end

   // pulse never comes without an enable one cycle earlier
   a_pulse_cause : assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i) pulse_o |-> $past(en_i))
      else $error("divider pulse without enable");

endmodule // fldm_pulse_div
`default_nettype wire

/* File: verilog/fldm_energy_acc.sv */
// Purpose: energy detector accumulator with hysteresis thresholds
// Assumes: tick_i is a 1 us enable pulse, sample_i a same-clock level
// Notes:   accumulator saturates; between thresholds the verdict holds
`timescale 1ns/1ns
`default_nettype none
module fldm_energy_acc
   import fldm_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             resetn_i,
   // sampling
   input  wire logic             tick_i,
   input  wire logic             sample_i,
   // settings
   input  wire logic [THR_W-1:0] win_len_i,
   input  wire logic [THR_W-1:0] on_thr_i,
   input  wire logic [THR_W-1:0] off_thr_i,
   // verdict
   output logic                  present_o,
   output logic                  lost_o
);
   logic [THR_W:0] acc_reg;
   logic [THR_W:0] acc_sum;
   logic           win_end;

   fldm_pulse_div #(.W(THR_W)) u_win (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .en_i      (tick_i),
      .period_i  (win_len_i),
      .pulse_o   (win_end)
   );

   // saturate rather than wrap, a wrap would fake an energy loss
   assign acc_sum = (tick_i && sample_i && !(&acc_reg)) ?
                    (THR_W+1)'(acc_reg + 1'b1) : acc_reg;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc_reg <= '0;
      end else begin
         acc_reg <= win_end ? '0 : acc_sum;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         present_o <= 1'b0;
         lost_o    <= 1'b0;
      end else if (win_end) begin
         if (acc_reg > {1'b0, on_thr_i}) begin
            present_o <= 1'b1;
            lost_o    <= 1'b0;
         end else if (acc_reg < {1'b0, off_thr_i}) begin
            present_o <= 1'b0;
            lost_o    <= 1'b1;
         end
      end
   end

   a_energy_on : assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      win_end && (acc_reg > {1'b0, on_thr_i}) |=> present_o && !lost_o)
      else $error("energy present not raised above on threshold");

   a_energy_off : assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      win_end && (acc_reg <= {1'b0, on_thr_i})
      && (acc_reg < {1'b0, off_thr_i}) |=> lost_o && !present_o)
      else $error("energy lost not raised below off threshold");

   a_energy_hold : assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i)
      !win_end |=> $stable(lost_o) && $stable(present_o))
      else $error("energy verdict changed outside window end");

endmodule // fldm_energy_acc
`default_nettype wire

/* File: verilog/fldm_monitor.sv */
// Purpose: fast link-drop monitor for a copper PHY receive path
// Assumes: receive indications come from logic on clk_sys_i
// Notes:   criteria are sampled over a window of 1 us ticks
// Behaviour
// - silence-drop enable drops link and stops transmit once no signal
// - skip-wait bit bypasses the maximum wait timer before the drop
// - five cause flags latch high on event, clear when register read
// - five enable bits arm criteria independently, any mix allowed
// - enables: energy, mse, mlt3, rx error, descrambler sync loss
// - three-bit field, reset 2, sets energy accumulation window length
// - energy present when accumulator exceeds on threshold, reset 2
// - energy lost when accumulator falls below the off threshold
// - five-bit field, reset 10, sets criteria window in microseconds
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module fldm_monitor
   import fldm_pkg::*;
#(
   parameter int unsigned MAX_WAIT_US = MAX_WAIT_US_DEF
) (
   // clock and reset
   input  wire logic          clk_sys_i,
   input  wire logic          resetn_i,
   // register port
   input  wire fldm_bus_req_t bus_i,
   output logic [DATA_W-1:0]  rd_data_o,
   // receive-path indications
   input  wire fldm_rx_ind_t  rx_ind_i,
   // link control and status
   output logic               link_down_o,
   output logic               tx_enable_o,
   output logic               energy_present_o,
   output logic               energy_lost_o,
   output logic               irq_o
);
   localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(MAX_WAIT_US - 1);

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   logic                 silence_en_reg;
   logic                 skip_wait_reg;
   logic [N_CRIT-1:0]    modes_reg;
   logic [N_CRIT-1:0]    cause_reg;
   logic [THR_W-1:0]     win_len_reg;
   logic [THR_W-1:0]     on_thr_reg;
   logic [THR_W-1:0]     off_thr_reg;
   logic [WIN_CNT_W-1:0] win_cnt_reg;
   logic [IRQ_W-1:0]     irq_stat_reg;
   logic [IRQ_W-1:0]     irq_mask_reg;
   logic [N_CRIT-1:0]    seen_reg;
   logic [WAIT_W-1:0]    wait_cnt_reg;
   logic                 silent_q;
   fldm_state_t          state_reg;
   fldm_state_t          state_next;

   logic                 us_tick;
   logic                 win_end;
   logic                 e_present;
   logic                 e_lost;
   logic [N_CRIT-1:0]    ev;
   logic [N_CRIT-1:0]    hit;
   logic                 any_hit;
   logic                 silent;
   logic                 link_down_next;
   logic                 wait_done;
   logic [IRQ_W-1:0]     irq_ev;
   logic [DATA_W-1:0]    rd_value;
   logic                 wr_cfg;
   logic                 wr_thr;
   logic                 wr_win;
   logic                 wr_stat;
   logic                 wr_mask;
   logic                 rd_cfg;

   // timebase and windows
   fldm_pulse_div #(.W(TICK_W)) u_us_div (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .en_i      (1'b1),
      .period_i  (TICK_CYCLES),
      .pulse_o   (us_tick)
   );

   fldm_pulse_div #(.W(WIN_CNT_W)) u_crit_win (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .en_i      (us_tick),
      .period_i  (win_cnt_reg),
      .pulse_o   (win_end)
   );

   fldm_energy_acc u_energy (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .tick_i    (us_tick),
      .sample_i  (rx_ind_i.energy_sample),
      .win_len_i (win_len_reg),
      .on_thr_i  (on_thr_reg),
      .off_thr_i (off_thr_reg),
      .present_o (e_present),
      .lost_o    (e_lost)
   );

   // register decode
   assign wr_cfg  = bus_i.wr && (bus_i.addr == ADDR_CFG);
   assign wr_thr  = bus_i.wr && (bus_i.addr == ADDR_THR);
   assign wr_win  = bus_i.wr && (bus_i.addr == ADDR_WIN_CNT);
   assign wr_stat = bus_i.wr && (bus_i.addr == ADDR_IRQ_STAT);
   assign wr_mask = bus_i.wr && (bus_i.addr == ADDR_IRQ_MASK);
   assign rd_cfg  = bus_i.rd && (bus_i.addr == ADDR_CFG);

   // criterion events in enable-bit order
   always_comb begin
      ev              = '0;
      ev[CRIT_ENERGY] = e_lost;
      ev[CRIT_MSE]    = rx_ind_i.mse_bad;
      ev[CRIT_MLT3]   = rx_ind_i.mlt3_err;
      ev[CRIT_RXERR]  = rx_ind_i.rx_err;
      ev[CRIT_DESCR]  = rx_ind_i.descr_sync_lost;
   end

   // each enable gates only its own criterion
   assign hit     = modes_reg & (seen_reg | ev);
   assign any_hit = |hit;
   assign silent  = silence_en_reg && !rx_ind_i.signal_present;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         silence_en_reg <= 1'b0;
         skip_wait_reg  <= 1'b0;
         modes_reg      <= '0;
      end else if (wr_cfg) begin
         silence_en_reg <= bus_i.wdata[CFG_SILENCE_BIT];
         skip_wait_reg  <= bus_i.wdata[CFG_SKIP_BIT];
         modes_reg      <= bus_i.wdata[CFG_MODES_LSB +: N_CRIT];
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         win_len_reg <= THR_RST[THR_WIN_LSB +: THR_W];
         on_thr_reg  <= THR_RST[THR_ON_LSB +: THR_W];
         off_thr_reg <= THR_RST[THR_OFF_LSB +: THR_W];
      end else if (wr_thr) begin
         win_len_reg <= bus_i.wdata[THR_WIN_LSB +: THR_W];
         on_thr_reg  <= bus_i.wdata[THR_ON_LSB +: THR_W];
         off_thr_reg <= bus_i.wdata[THR_OFF_LSB +: THR_W];
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         win_cnt_reg <= WIN_CNT_RST;
      end else if (wr_win) begin
         win_cnt_reg <= bus_i.wdata[WIN_CNT_LSB +: WIN_CNT_W];
      end
   end

   // events seen inside the current window; a fresh window starts empty
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seen_reg <= '0;
      end else begin
         seen_reg <= win_end ? '0 : (seen_reg | ev);
      end
   end

   // cause flags: a set in the read cycle survives the clear
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cause_reg <= '0;
      end else begin
         cause_reg <= (rd_cfg ? '0 : cause_reg)
                      | (win_end ? hit : '0);
      end
   end

   // drop sequencing
   assign wait_done = us_tick && (wait_cnt_reg == WAIT_LAST);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (win_end && any_hit) begin
               state_next = skip_wait_reg ? ST_DOWN : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (win_end && !any_hit) begin
               state_next = ST_IDLE;
            end else if (wait_done) begin
               state_next = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (win_end && !any_hit) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_cnt_reg <= '0;
      end else if (state_reg != ST_WAIT) begin
         wait_cnt_reg <= '0;
      end else if (us_tick && !wait_done) begin
         wait_cnt_reg <= WAIT_W'(wait_cnt_reg + 1'b1);
      end
   end

   // silence bypasses the window so transmit stops at once
   assign link_down_next = (state_next == ST_DOWN) || silent;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         link_down_o      <= 1'b0;
         tx_enable_o      <= 1'b1;
         energy_present_o <= 1'b0;
         energy_lost_o    <= 1'b0;
         silent_q         <= 1'b0;
      end else begin
         link_down_o      <= link_down_next;
         tx_enable_o      <= !link_down_next;
         energy_present_o <= e_present;
         energy_lost_o    <= e_lost;
         silent_q         <= silent;
      end
   end

   // interrupts
   always_comb begin
      irq_ev                 = '0;
      irq_ev[IRQ_DROP_BIT]   = (state_reg != ST_DOWN)
                               && (state_next == ST_DOWN);
      irq_ev[IRQ_SILENT_BIT] = silent && !silent_q;
      irq_ev[IRQ_ELOST_BIT]  = e_lost && !energy_lost_o;
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq_o        <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg
                          & ~(wr_stat ? bus_i.wdata[IRQ_W-1:0] : '0))
                         | irq_ev;
         if (wr_mask) begin
            irq_mask_reg <= bus_i.wdata[IRQ_W-1:0];
         end
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // read-back; unmapped addresses read zero
   always_comb begin
      rd_value = '0;
      unique case (bus_i.addr)
         ADDR_CFG: begin
            rd_value[CFG_SILENCE_BIT]             = silence_en_reg;
            rd_value[CFG_SKIP_BIT]                = skip_wait_reg;
            rd_value[CFG_CAUSE_LSB +: N_CRIT]     = cause_reg;
            rd_value[CFG_MODES_LSB +: N_CRIT]     = modes_reg;
         end
         ADDR_THR: begin
            rd_value[THR_WIN_LSB +: THR_W]        = win_len_reg;
            rd_value[THR_ON_LSB +: THR_W]         = on_thr_reg;
            rd_value[THR_OFF_LSB +: THR_W]        = off_thr_reg;
         end
         ADDR_WIN_CNT: begin
            rd_value[WIN_CNT_LSB +: WIN_CNT_W]    = win_cnt_reg;
         end
         ADDR_IRQ_STAT: rd_value[IRQ_W-1:0]       = irq_stat_reg;
         ADDR_IRQ_MASK: rd_value[IRQ_W-1:0]       = irq_mask_reg;
         default:       rd_value                  = '0;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= bus_i.rd ? rd_value : '0;
      end
   end

   // checks
   sequence s_silent;
      silence_en_reg && !rx_ind_i.signal_present;
   endsequence

   sequence s_idle_hit;
      (state_reg == ST_IDLE) && win_end && any_hit;
   endsequence

   a_silence_drop : assert property (s_silent |=>
      link_down_o && !tx_enable_o)
      else $error("silence did not drop the link");

   a_skip_wait : assert property (s_idle_hit
      ##0 skip_wait_reg |=> (state_reg == ST_DOWN) ##1 link_down_o)
      else $error("skip-wait did not drop at once");

   a_wait_used : assert property (s_idle_hit
      ##0 !skip_wait_reg && !silent |=> (state_reg == ST_WAIT) && !link_down_o)
      else $error("wait timer stage not entered");

   a_cause_hold : assert property ((|cause_reg) && !rd_cfg
      |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
      else $error("cause flag dropped without a read");

   a_cause_clear : assert property (rd_cfg && !win_end
      |=> cause_reg == '0)
      else $error("cause flags not cleared by read");

   a_modes_gate : assert property ((state_reg == ST_IDLE)
      && (modes_reg == '0) && !silent |=> !link_down_o)
      else $error("link dropped with no criterion armed");

   a_cause_map : assert property (win_end && any_hit
      |=> (cause_reg & $past(hit)) == $past(hit))
      else $error("cause flag not set at criterion position");

   a_energy_map : assert property (win_end
      && modes_reg[CRIT_ENERGY] && e_lost |=> cause_reg[CRIT_ENERGY])
      else $error("energy loss not mapped to bit zero");

   a_reset_vals : assert property ($rose(resetn_i)
      |-> win_cnt_reg == WIN_CNT_RST && on_thr_reg == THR_RST[THR_ON_LSB+:THR_W])
      else $error("window or threshold reset value wrong");

endmodule // fldm_monitor
`default_nettype wire

/* File: bench/fldm_partner.sv */
// Purpose: remote link partner as seen through the receive indications
// Assumes: bench selects silence and one fault line per criterion
// Notes:   error strobes are sparse pulses, which stresses event latching
`timescale 1ns/1ns
`default_nettype none
module fldm_partner
   import fldm_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   // scenario control
   input  wire logic              silent_i,
   input  wire logic [N_CRIT-1:0] fault_i,
   // receive indications
   output var fldm_rx_ind_t       rx_o
);
   logic [1:0] ph_reg;
   logic       hit;

   // a real line reports errors in bursts, not as steady levels
   assign hit = (ph_reg == 2'h0);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ph_reg <= 2'h0;
         rx_o   <= '0;
      end else begin
         ph_reg                  <= ph_reg + 2'h1;
         rx_o.signal_present     <= !silent_i;
         rx_o.energy_sample      <= !silent_i && !fault_i[CRIT_ENERGY];
         rx_o.mse_bad            <= fault_i[CRIT_MSE];
         rx_o.mlt3_err           <= fault_i[CRIT_MLT3] && hit;
         rx_o.rx_err             <= fault_i[CRIT_RXERR] && hit;
         rx_o.descr_sync_lost    <= fault_i[CRIT_DESCR];
      end
   end
endmodule // fldm_partner
`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the fast link-drop monitor
// Assumes: criteria window set to 1 us, wait timer shortened to 2 ticks
// Notes:   register access follows the one-cycle strobe port
`timescale 1ns/1ns
`default_nettype none
module testbench
   import fldm_pkg::*;
;
   localparam int unsigned WAIT_US = 2;

   logic              clk_sys_i;
   logic              resetn_i;
   fldm_bus_req_t     bus;
   logic [DATA_W-1:0] rd_data;
   fldm_rx_ind_t      rx;
   logic              link_down;
   logic              tx_en;
   logic              e_present;
   logic              e_lost;
   logic              irq;
   logic              silent;
   logic [N_CRIT-1:0] fault;
   int                errors;
   int                comparisons;
   int                n;
   int                t_fast;
   int                t_slow;

   fldm_monitor #(.MAX_WAIT_US(WAIT_US)) dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .bus_i(bus), .rd_data_o(rd_data), .rx_ind_i(rx),
      .link_down_o(link_down), .tx_enable_o(tx_en),
      .energy_present_o(e_present), .energy_lost_o(e_lost),
      .irq_o(irq));

   fldm_partner partner (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .silent_i(silent), .fault_i(fault), .rx_o(rx));

   task automatic check(string what, logic [DATA_W-1:0] exp,
                        logic [DATA_W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_flag(string what, logic exp, logic got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_chk(string what, logic [ADDR_W-1:0] a,
                         logic [DATA_W-1:0] m, logic [DATA_W-1:0] exp);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus.rd <= 1'b0;
      #1;
      check(what, exp, rd_data & m);
   endtask

   task automatic wait_link(logic lvl, int max, output int cyc);
      cyc = 0;
      #1;
      while (link_down !== lvl && cyc < max) begin
         @(posedge clk_sys_i);
         #1;
         cyc++;
      end
      check_flag("link_down", lvl, link_down);
   endtask

   // clear fault, wait for recovery, then drain latched flags
   task automatic recover(logic [DATA_W-1:0] cfg);
      @(posedge clk_sys_i);
      fault  <= '0;
      silent <= 1'b0;
      wait_link(1'b0, 3000, n);
      rd_chk("cfg drain", ADDR_CFG, 16'hC01F, cfg);
      rd_chk("cfg cleared", ADDR_CFG, 16'hFFFF, cfg);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      #(60000 * CLK_PERIOD_NS);
      errors++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      errors      = 0;
      comparisons = 0;
      resetn_i    = 1'b0;
      bus         = '0;
      silent      = 1'b0;
      fault       = '0;
      repeat (5) @(posedge clk_sys_i);
      resetn_i <= 1'b1;

      rd_chk("cfg reset", ADDR_CFG, 16'hFFFF, 16'h0000);
      rd_chk("thr reset", ADDR_THR, 16'hFFFF, THR_RST);
      rd_chk("win reset", ADDR_WIN_CNT, 16'h3E00, 16'h1400);
      rd_chk("mask reset", ADDR_IRQ_MASK, 16'hFFFF, 16'h0000);
      rd_chk("unmapped", 8'h10, 16'hFFFF, 16'h0000);
      wr(ADDR_THR, 16'hFFFF);
      rd_chk("thr fields", ADDR_THR, 16'hFFFF, 16'h0777);
      wr(ADDR_CFG, 16'hFFFF);
      rd_chk("cfg fields", ADDR_CFG, 16'hFFFF, 16'hC01F);
      wr(ADDR_CFG, 16'h0000);
      wr(ADDR_WIN_CNT, 16'hFFFF);
      rd_chk("win field", ADDR_WIN_CNT, 16'hFFFF, 16'h3E00);
      wr(ADDR_WIN_CNT, 16'h0200);
      // window 7 lets the count clear the on threshold of 2
      wr(ADDR_THR, 16'h0721);
      n = 0;
      while (e_present !== 1'b1 && n < 2000) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      check_flag("energy present", 1'b1, e_present);
      $display("test registers done");

      for (int i = 0; i < N_CRIT; i++) begin
         wr(ADDR_CFG, 16'h4000 | (16'h0001 << i));
         @(posedge clk_sys_i);
         fault <= 5'h01 << i;
         wait_link(1'b1, 3000, n);
         check_flag("tx_enable", 1'b0, tx_en);
         check_flag("irq masked", 1'b0, irq);
         rd_chk("irq drop", ADDR_IRQ_STAT, 16'h0005,
                (i == 0) ? 16'h0005 : 16'h0001);
         wr(ADDR_IRQ_STAT, 16'h0007);
         if (i == 0) begin
            check_flag("energy lost", 1'b1, e_lost);
            check_flag("energy gone", 1'b0, e_present);
         end
         rd_chk("cause", ADDR_CFG, 16'hFFFF,
                16'h4000 | (16'h0001 << i) | (16'h0100 << i));
         recover(16'h4000 | (16'h0001 << i));
         $display("test criterion %0d done", i);
      end

      // bit 2 disarmed: its fault must leave neither drop nor flag
      wr(ADDR_CFG, 16'h400A);
      @(posedge clk_sys_i);
      fault <= 5'h04;
      repeat (300) @(posedge clk_sys_i);
      #1;
      check_flag("disarmed", 1'b0, link_down);
      @(posedge clk_sys_i);
      fault <= 5'h0E;
      wait_link(1'b1, 3000, n);
      rd_chk("mixed cause", ADDR_CFG, 16'hFFFF, 16'h4A0A);
      recover(16'h400A);
      $display("test combination done");

      for (int s = 0; s < 2; s++) begin
         wr(ADDR_CFG, (s == 1) ? 16'h4008 : 16'h0008);
         @(posedge clk_sys_i);
         fault <= 5'h08;
         wait_link(1'b1, 3000, n);
         if (s == 1) t_fast = n;
         else t_slow = n;
         recover((s == 1) ? 16'h4008 : 16'h0008);
      end
      check_flag("wait bypass", 1'b1, t_slow >= t_fast + 100 * (WAIT_US - 1)
                 && t_slow <= 100 * (WAIT_US + 1) + 10);
      $display("test wait timer done");

      wr(ADDR_IRQ_STAT, 16'h0007);
      wr(ADDR_IRQ_MASK, 16'h0002);
      wr(ADDR_CFG, 16'h8000);
      @(posedge clk_sys_i);
      silent <= 1'b1;
      wait_link(1'b1, 4, n);
      check_flag("tx stopped", 1'b0, tx_en);
      repeat (3) @(posedge clk_sys_i);
      #1;
      check_flag("irq raised", 1'b1, irq);
      rd_chk("irq status", ADDR_IRQ_STAT, 16'h0002, 16'h0002);
      wr(ADDR_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check_flag("irq masked off", 1'b0, irq);
      recover(16'h8000);
      wr(ADDR_IRQ_STAT, 16'h0007);
      wr(ADDR_IRQ_MASK, 16'h0002);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check_flag("irq cleared", 1'b0, irq);
      check_flag("tx resumed", 1'b1, tx_en);
      $display("test silence done");
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
